// *** pkg/qdsl_pkg.sv ***
// shared constants for the quad converter serial load control block
package qdsl_pkg;

  // ----------------------------------------------------------------
  // serial word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int CODE_W = 12;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 14;
  localparam int CODE_MSB = 11;
  localparam int N_CHAN = 4;
  localparam int JOHN_W = 4;

  // ----------------------------------------------------------------
  // reset codes
  // ----------------------------------------------------------------
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_MID = 12'h800;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CHA = 8'h08;
  localparam logic [7:0] ADDR_CHB = 8'h0C;
  localparam logic [7:0] ADDR_CHC = 8'h10;
  localparam logic [7:0] ADDR_CHD = 8'h14;
  localparam int CTRL_HOLD_BIT = 0;
  localparam logic CTRL_HOLD_RST = 1'b0;
  localparam int STAT_STROBE_BIT = 16;
  localparam int STAT_RST_BIT = 17;
  localparam int STAT_PICK_BIT = 18;
  localparam int STAT_QUIET_BIT = 19;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // crossing
  // ----------------------------------------------------------------
  localparam int QUIET_CYC_DEF = 3;

endpackage : qdsl_pkg

// *** design/qdsl_shift.sv ***
// serial-to-parallel shift register clocked by the combined shift clock
`timescale 1ns/1ps
module qdsl_shift
  import qdsl_pkg::*;
(
  // link clock
  input wire logic shift_clk,
  // serial data
  input wire logic serial_in,
  // parallel view
  output logic [qdsl_pkg::WORD_W-1:0] word,
  output logic [qdsl_pkg::JOHN_W-1:0] step_cnt
);
  import qdsl_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic [JOHN_W-1:0] cnt;
  } qdsl_lnk_t;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // no reset here: the device reset must not disturb the shifted word and
  // the link clock may never run while a reset is applied
  qdsl_lnk_t st_r = '0;
  qdsl_lnk_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.word = {st_r.word[WORD_W-2:0], serial_in};
    // johnson step count: one bit changes per shift, safe to synchronise
    st_nxt.cnt = {st_r.cnt[JOHN_W-2:0], ~st_r.cnt[JOHN_W-1]};
  end

  always_ff @(posedge shift_clk) begin
    st_r <= st_nxt;
  end

  assign word = st_r.word;
  assign step_cnt = st_r.cnt;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_SHIFT_ONE_BIT: assert property (
    @(posedge shift_clk) disable iff (1'b0)
    1'b1 |=> (st_r.word == {$past(st_r.word[WORD_W-2:0]), $past(serial_in)}))
    else $error("shift register did not advance exactly one bit");

  AST_STEP_ONE_CHANGE: assert property (
    @(posedge shift_clk) disable iff (1'b0)
    1'b1 |=> ($countones(st_r.cnt ^ $past(st_r.cnt)) == 1))
    else $error("step count changed more than one bit per shift");

endmodule : qdsl_shift

// *** design/qdsl_top.sv ***
// quad converter serial load control: shift path, channel registers, axi4-lite view
//
// How it works
// - a word is 16 bits: 2 address bits, 2 ignored bits, 12 code bits
// - address bits enter first, then ignored bits, then code msb first
// - strobe low and no reset: addressed channel transparent; strobe high: all hold (all also hold while the ctrl hold bit is set)
// - reset low forces all channels to 000 or 800 by the pick pin
// - after reset release, latched channels keep the reset code until loaded
// - device reset leaves the serial shift register untouched
// - shift register is clocked by select OR serial clock
// - shift on clock rise with select low, or select rise with clock low
// - select rising while clock low shifts one extra bit
// - shifting with strobe low drags the load across passing channels
// - codes are straight binary, step is code over 4096 of span
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module qdsl_top
  import qdsl_pkg::*;
#(
  parameter int QUIET_CYC = qdsl_pkg::QUIET_CYC_DEF
) (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [qdsl_pkg::AXI_AW-1:0] awaddr,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [qdsl_pkg::AXI_AW-1:0] araddr,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // serial link pins
  input wire logic ser_clk,
  input wire logic select_n,
  input wire logic serial_in,
  // load and reset pins
  input wire logic load_strobe_n,
  input wire logic dev_reset_n,
  input wire logic reset_code_pick,
  // channel codes
  output logic [qdsl_pkg::CODE_W-1:0] chan_a_code,
  output logic [qdsl_pkg::CODE_W-1:0] chan_b_code,
  output logic [qdsl_pkg::CODE_W-1:0] chan_c_code,
  output logic [qdsl_pkg::CODE_W-1:0] chan_d_code
);
  import qdsl_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (QUIET_CYC < 2 || QUIET_CYC > 7) begin : g_bad_quiet
    $error("QUIET_CYC must lie between 2 and 7");
  end

  typedef struct packed {
    logic [1:0] strobe_s;
    logic [1:0] rst_s;
    logic [1:0] pick_s;
    logic [JOHN_W-1:0] cnt_m;
    logic [JOHN_W-1:0] cnt_q;
    logic [JOHN_W-1:0] cnt_prev;
    logic [2:0] quiet_cnt;
    logic [WORD_W-1:0] word;
    logic [N_CHAN-1:0][CODE_W-1:0] chan;
    logic hold;
    logic aw_got;
    logic [AXI_AW-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } qdsl_st_t;

  qdsl_st_t st_r;
  qdsl_st_t st_nxt;

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  logic shift_clk;
  logic [WORD_W-1:0] link_word;
  logic [JOHN_W-1:0] link_cnt;

  // either input can advance the register; a select rise with the clock low
  // is a real edge here and shifts an extra bit
  assign shift_clk = select_n | ser_clk;

  qdsl_shift u_shift (
    .shift_clk(shift_clk),
    .serial_in(serial_in),
    .word(link_word),
    .step_cnt(link_cnt)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic quiet;
  logic rst_act;
  logic [2:0] q_lim;
  logic do_write;
  logic [31:0] rd_val;
  logic rd_ok;

  assign q_lim = 3'(QUIET_CYC);
  assign quiet = (st_r.quiet_cnt == q_lim);
  assign rst_act = ~st_r.rst_s[1];

  // read mux over the current state
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (araddr == ADDR_CTRL) begin
      rd_val[CTRL_HOLD_BIT] = st_r.hold;
    end else if (araddr == ADDR_STAT) begin
      rd_val[WORD_W-1:0] = st_r.word;
      rd_val[STAT_STROBE_BIT] = st_r.strobe_s[1];
      rd_val[STAT_RST_BIT] = st_r.rst_s[1];
      rd_val[STAT_PICK_BIT] = st_r.pick_s[1];
      rd_val[STAT_QUIET_BIT] = quiet;
    end else if (araddr == ADDR_CHA) begin
      rd_val[CODE_W-1:0] = st_r.chan[0];
    end else if (araddr == ADDR_CHB) begin
      rd_val[CODE_W-1:0] = st_r.chan[1];
    end else if (araddr == ADDR_CHC) begin
      rd_val[CODE_W-1:0] = st_r.chan[2];
    end else if (araddr == ADDR_CHD) begin
      rd_val[CODE_W-1:0] = st_r.chan[3];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_comb begin
    st_nxt = st_r;
    do_write = 1'b0;
    // pin synchronisers: first stage feeds only the second
    st_nxt.strobe_s = {st_r.strobe_s[0], load_strobe_n};
    st_nxt.rst_s = {st_r.rst_s[0], dev_reset_n};
    st_nxt.pick_s = {st_r.pick_s[0], reset_code_pick};
    st_nxt.cnt_m = link_cnt;
    st_nxt.cnt_q = st_r.cnt_m;
    st_nxt.cnt_prev = st_r.cnt_q;
    // the shifted word is only copied once the link has been still for a
    // while, so it is never sampled while it moves
    if (st_r.cnt_q != st_r.cnt_prev) begin
      st_nxt.quiet_cnt = 3'h0;
    end else if (!quiet) begin
      st_nxt.quiet_cnt = st_r.quiet_cnt + 3'h1;
    end
    if (quiet) begin
      st_nxt.word = link_word;
    end

    // channel registers: reset dominates, then the transparent load
    if (rst_act) begin
      for (int i = 0; i < N_CHAN; i++) begin
        st_nxt.chan[i] = st_r.pick_s[1] ? CODE_MID : CODE_ZERO;
      end
    end else if (!st_r.strobe_s[1] && !st_r.hold) begin
      // the address follows the word as it flows, so loading while
      // shifting writes into every channel it passes
      st_nxt.chan[st_r.word[ADDR_MSB:ADDR_LSB]] = st_r.word[CODE_MSB:0];
    end

    // write channel: address and data taken in either order
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = wdata;
      st_nxt.w_strb = wstrb;
    end
    if (st_nxt.aw_got && st_nxt.w_got && !st_r.bvalid) begin
      do_write = 1'b1;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      if (st_nxt.aw_addr == ADDR_CTRL) begin
        if (st_nxt.w_strb[0]) begin
          st_nxt.hold = st_nxt.w_data[CTRL_HOLD_BIT];
        end
      end else if (st_nxt.aw_addr == ADDR_STAT || st_nxt.aw_addr == ADDR_CHA ||
                   st_nxt.aw_addr == ADDR_CHB || st_nxt.aw_addr == ADDR_CHC ||
                   st_nxt.aw_addr == ADDR_CHD) begin
        // read-only registers take the write silently
        st_nxt.bresp = RESP_OKAY;
      end else begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end

    // read channel
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_val;
      st_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // ready flags registered from the next state
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid && !do_write;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid && !do_write;
    st_nxt.arready = !st_nxt.rvalid;

    if (!aresetn) begin
      st_nxt = '0;
      st_nxt.strobe_s = 2'h3;
      st_nxt.rst_s = 2'h3;
      for (int i = 0; i < N_CHAN; i++) begin
        st_nxt.chan[i] = CODE_ZERO;
      end
      st_nxt.hold = CTRL_HOLD_RST;
    end
  end

  always_ff @(posedge aclk) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // codes leave as plain straight binary; the ladder scales by code/4096
  assign chan_a_code = st_r.chan[0];
  assign chan_b_code = st_r.chan[1];
  assign chan_c_code = st_r.chan[2];
  assign chan_d_code = st_r.chan[3];
  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RESET_FORCE: assert property (
    rst_act |=> (st_r.chan == {N_CHAN{$past(st_r.pick_s[1]) ? CODE_MID : CODE_ZERO}}))
    else $error("reset did not force the selected reset code");

  AST_HOLD_ALL: assert property (
    (st_r.strobe_s[1] && !rst_act) |=> $stable(st_r.chan))
    else $error("channel changed while strobe was high");

  AST_RELEASE_KEEP: assert property (
    ($rose(st_r.rst_s[1]) && st_r.strobe_s[1]) ##1
    (st_r.rst_s[1] && st_r.strobe_s[1])[*2] |=> (st_r.chan == $past(st_r.chan, 3)))
    else $error("reset code lost after release without a load");

  AST_LOAD_SELECTED: assert property (
    (!st_r.strobe_s[1] && !rst_act && !st_r.hold) |=>
    (st_r.chan[$past(st_r.word[ADDR_MSB:ADDR_LSB])] == $past(st_r.word[CODE_MSB:0])))
    else $error("addressed channel did not take the code bits");

  AST_OTHERS_KEEP: assert property (
    (!st_r.strobe_s[1] && !rst_act && st_r.word[ADDR_MSB:ADDR_LSB] != 2'h0) |=>
    $stable(st_r.chan[0]))
    else $error("unaddressed channel changed during a load");

  AST_CTRL_HOLD: assert property (
    (st_r.hold && !rst_act) |=> $stable(st_r.chan))
    else $error("channel changed while software hold was set");

  AST_WRITE_ANSWER: assert property (
    (awvalid && awready && wvalid && wready) |=> (bvalid && !awready && !wready))
    else $error("write response not raised after address and data");

  AST_READ_STANDS: assert property (
    (rvalid && !rready) |=> (rvalid && $stable(rdata) && $stable(rresp)))
    else $error("read answer dropped or changed before it was taken");

  AST_READ_ANSWER: assert property (
    (arvalid && arready) |=> (rvalid && !arready))
    else $error("read answer not raised one cycle after the address");

endmodule : qdsl_top

// *** testbench/qdsl_host.sv ***
// host model driving the serial link, load strobe and device reset pins
`timescale 1ns/1ps
// pins start known before time zero: the gated shift clock rises out of the
// unknown state at time zero and must not take an unknown data bit
module qdsl_host (
  // serial link
  output logic ser_clk = 1'h1,
  output logic select_n = 1'h1,
  output logic serial_in = 1'h0,
  // load and reset
  output logic load_strobe_n = 1'h1,
  output logic dev_reset_n = 1'h1,
  output logic reset_code_pick = 1'h0
);
  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  localparam time HALF = 15;
  // mode 0: clock with select low, 1: select only, 2: select raised with clock low
  task automatic send_word(input logic [15:0] w, input int mode);
    if (mode == 1) ser_clk = 1'h0;
    else select_n = 1'h0;
    #HALF;
    for (int i = 15; i >= 0; i--) begin
      serial_in = w[i];
      if (mode == 1) select_n = 1'h0;
      else ser_clk = 1'h0;
      #HALF;
      if (mode == 1) select_n = 1'h1;
      else ser_clk = 1'h1;
      #HALF;
    end
    if (mode == 2) begin
      ser_clk = 1'h0;
      serial_in = ~w[0];
      #HALF;
    end
    select_n = 1'h1;
    #HALF;
    ser_clk = 1'h1;
    // released data line must not look like a held value
    serial_in = ~serial_in;
  endtask : send_word
  // long gap: the word has to cross into the system clock first
  task automatic load_word();
    #700;
    load_strobe_n = 1'h0;
    #500;
    load_strobe_n = 1'h1;
    #500;
  endtask : load_word
  task automatic reset_on(input logic pick);
    reset_code_pick = pick;
    #400;
    dev_reset_n = 1'h0;
    #500;
  endtask : reset_on
  task automatic reset_off();
    dev_reset_n = 1'h1;
    #500;
  endtask : reset_off
endmodule : qdsl_host

// *** testbench/qdsl_top_test.sv ***
// self-checking bench: axi4-lite master, host model and channel model
`timescale 1ns/1ps
module qdsl_top_test;
  import qdsl_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic aclk = 1'h0, aresetn = 1'h0, hold = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rs;
  logic ser_clk, select_n, serial_in, load_strobe_n, dev_reset_n, reset_code_pick;
  logic [11:0] chan_a_code, chan_b_code, chan_c_code, chan_d_code;
  logic [11:0] exp_ch [4];
  logic [31:0] seed = 32'h3F88C7C2;
  logic [15:0] w;
  int fail_count = 0, compares = 0, cyc = 0;
  always #50 aclk = ~aclk;
  qdsl_top #(.QUIET_CYC(3)) i_qdsl_top (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .ser_clk, .select_n, .serial_in,
    .load_strobe_n, .dev_reset_n, .reset_code_pick, .chan_a_code, .chan_b_code,
    .chan_c_code, .chan_d_code);
  qdsl_host i_qdsl_host (.ser_clk, .select_n, .serial_in, .load_strobe_n, .dev_reset_n,
    .reset_code_pick);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : axi_rd
  task automatic check_chans();
    check({chan_a_code, chan_b_code, chan_c_code, chan_d_code},
      {exp_ch[0], exp_ch[1], exp_ch[2], exp_ch[3]});
    for (int k = 0; k < N_CHAN; k++) begin
      axi_rd(ADDR_CHA + 8'(4 * k), rd, rs);
      check({14'h0, rs, rd}, {14'h0, RESP_OKAY, 20'h0, exp_ch[k]});
    end
  endtask : check_chans
  task automatic put_word(input logic [15:0] v, input int mode);
    logic [15:0] s;
    i_qdsl_host.send_word(v, mode);
    s = (mode == 2) ? {v[14:0], ~v[0]} : v;
    i_qdsl_host.load_word();
    if (!hold) exp_ch[s[15:14]] = s[11:0];
    check_chans();
    axi_rd(ADDR_STAT, rd, rs);
    check({14'h0, rs, rd}, {14'h0, RESP_OKAY, 12'h0, 1'h1, reset_code_pick, 2'h3, s});
  endtask : put_word
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    exp_ch = '{default: CODE_ZERO};
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(ADDR_CTRL, rd, rs);
    check({14'h0, rs, rd}, {14'h0, RESP_OKAY, 31'h0, CTRL_HOLD_RST});
    axi_rd(8'h40, rd, rs);
    check({14'h0, rs, rd}, {14'h0, RESP_SLVERR, 32'h0});
    axi_wr(8'h40, 32'h1, rs);
    check(48'(rs), 48'(RESP_SLVERR));
    axi_wr(ADDR_CHA, 32'hFFF, rs);
    check(48'(rs), 48'(RESP_OKAY));
    check_chans();
    $display("test defaults done");
    for (int i = 0; i < 12; i++) begin
      w = 16'(rnd());
      if (i < 2) w[11:0] = (i == 0) ? 12'hFFF : 12'h000;
      put_word(w, i % 3);
    end
    $display("test words done");
    axi_wr(ADDR_CTRL, 32'h1, rs);
    hold = 1'h1;
    put_word(16'(rnd()), 0);
    axi_wr(ADDR_CTRL, 32'h0, rs);
    hold = 1'h0;
    $display("test hold done");
    for (int p = 1; p >= 0; p--) begin
      w = 16'(rnd());
      i_qdsl_host.send_word(w, 0);
      i_qdsl_host.reset_on(p[0]);
      exp_ch = '{default: (p == 1) ? CODE_MID : CODE_ZERO};
      check_chans();
      i_qdsl_host.reset_off();
      check_chans();
      i_qdsl_host.load_word();
      exp_ch[w[15:14]] = w[11:0];
      check_chans();
    end
    $display("test reset done");
    finish_test();
  end
endmodule : qdsl_top_test
